/* File: include/reset_boot_pkg.sv */
// Constants, types and carriers for reset merging and boot mode selection
// Functional notes
// RULE_01 - Five reset sources: POR, pin, watchdog, wake, brownout
// RULE_02 - Latch boot straps at reset end, hold
// RULE_03 - Board holds reset pin low about 500 us
// RULE_04 - RAM kept on warm resets, lost otherwise
// RULE_05 - Wake-up reset switches voltage regulator back on
// RULE_06 - Boot mode only after POR or pin reset
// RULE_07 - TMS low: mode pin picks user or loader
// RULE_08 - TMS high, port bit low: debug or JTAG-user
// RULE_09 - JTAG user mode keeps debug pins available
// RULE_10 - No password and zero byte: enter loader; the code does so only when the straps decode to plain user mode
// RULE_11 - Loader over CAN bypasses the oscillator
// RULE_12 - Board uses default UART and JTAG pins
// RULE_13 - Merge sources, release synchronously, sample straps then
package reset_boot_pkg;

  // Reset cause vector bit positions
  localparam int CAUSE_POR   = 0;
  localparam int CAUSE_PIN   = 1;
  localparam int CAUSE_WDT   = 2;
  localparam int CAUSE_WAKE  = 3;
  localparam int CAUSE_BROWN = 4;
  localparam int CAUSE_WIDTH = 5;

  // Values after reset
  localparam logic [4:0]  CAUSE_RESET_VALUE   = 5'h01;
  localparam logic [5:0]  SYNC_RESET_VALUE    = 6'h20;
  localparam logic [15:0] BOOT_START_ADDRESS  = 16'h0000;
  localparam logic [15:0] START_ADDRESS_RESET = 16'h0000;

  // Release stretch after the last source goes quiet
  localparam int RELEASE_STRETCH_CYCLES = 16;
  localparam int STRETCH_COUNT_WIDTH    = 8;

  // Board recommendation, not enforced by the device
  localparam int POWERUP_HOLD_US = 500;

  typedef enum logic [1:0] {
    BOOT_USER      = 2'b00,
    BOOT_LOADER    = 2'b01,
    BOOT_DEBUG     = 2'b10,
    BOOT_USER_JTAG = 2'b11
  } boot_mode_t;

  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_STRETCH = 2'b01,
    ST_RUN     = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic boot_mode_config_pin;
    logic tms;
    logic port0_bit0_strap;
  } strap_t;

  typedef struct packed {
    logic   reset_pin_n;
    logic   wakeup;
    logic   brownout;
    strap_t strap;
  } async_in_t;

endpackage

/* File: src/pin_sync3.sv */
// Three-stage synchroniser whose output moves when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
  parameter int               WIDTH       = 6,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] stable
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;

  // Only bits whose last two stages agree may update; filters one-cycle glitches
  always_comb begin
    stable_next = stable_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        stable_next[i] = s3_reg[i];
      end
    end
  end

  // First stage is read only by the second
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_reg     <= RESET_VALUE;
      s2_reg     <= RESET_VALUE;
      s3_reg     <= RESET_VALUE;
      stable_reg <= RESET_VALUE;
    end else begin
      s1_reg     <= async_in;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_reg <= stable_next;
    end
  end

  assign stable = stable_reg;

endmodule
`default_nettype wire

/* File: src/reset_boot_mode_select.sv */
// Reset source merge, synchronous release and boot strap mode latch
`timescale 1ns/1ns
`default_nettype none
module reset_boot_mode_select #(
  parameter int STRETCH_CYCLES = reset_boot_pkg::RELEASE_STRETCH_CYCLES
) (
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        RESET_PIN_N,
  input  wire logic        WATCHDOG_EXPIRE,
  input  wire logic        WAKEUP_REQUEST,
  input  wire logic        BROWNOUT_DETECT,
  input  wire logic        BOOT_MODE_CONFIG_PIN,
  input  wire logic        TMS_PIN,
  input  wire logic        PORT0_BIT0_STRAP,
  input  wire logic        PASSWORD_VALID,
  input  wire logic        MEM_ZERO_AT_START,
  input  wire logic        CAN_LOADER_ACTIVE,
  input  wire logic        POWER_DOWN_ENTRY,
  output var  logic        SYS_RESET,
  output var  logic [4:0]  RESET_CAUSE,
  output var  logic        RAM_RETAINED,
  output var  logic        REGULATOR_ON,
  output var  logic [1:0]  BOOT_MODE,
  output var  logic [15:0] START_ADDRESS,
  output var  logic        JTAG_PINS_ENABLE,
  output var  logic        OSC_BYPASS
);

  localparam int CW = reset_boot_pkg::STRETCH_COUNT_WIDTH;
  localparam logic [CW-1:0] STRETCH_LAST = CW'(STRETCH_CYCLES - 1);

  // Strap decode; the unlisted case, TMS high with port bit high, falls back to plain user mode
  function automatic reset_boot_pkg::boot_mode_t decode_straps(
    input reset_boot_pkg::strap_t s
  );
    reset_boot_pkg::boot_mode_t m;
    m = reset_boot_pkg::BOOT_USER;
    if (!s.tms) begin
      m = s.boot_mode_config_pin ? reset_boot_pkg::BOOT_USER
                                 : reset_boot_pkg::BOOT_LOADER; // [RULE_07]
    end else if (!s.port0_bit0_strap) begin
      m = s.boot_mode_config_pin ? reset_boot_pkg::BOOT_USER_JTAG
                                 : reset_boot_pkg::BOOT_DEBUG; // [RULE_08]
    end
    return m;
  endfunction

  reset_boot_pkg::async_in_t  async_raw;
  reset_boot_pkg::async_in_t  async_s;
  reset_boot_pkg::seq_state_t state_reg;
  reset_boot_pkg::seq_state_t state_next;
  reset_boot_pkg::boot_mode_t mode_reg;
  reset_boot_pkg::boot_mode_t mode_next;
  reset_boot_pkg::boot_mode_t strap_mode;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [4:0]    cause_reg;
  logic [4:0]    cause_next;
  logic [4:0]    src_vec;
  logic          src_any;
  logic          release_now;
  logic          cold_release;
  logic          sys_reset_reg;
  logic          sys_reset_next;
  logic          ram_reg;
  logic          ram_next;
  logic          reg_on_reg;
  logic          reg_on_next;
  logic          jtag_reg;
  logic          jtag_next;
  logic          bypass_reg;
  logic          bypass_next;
  logic [15:0]   start_reg;
  logic [15:0]   start_next;

  // Pin-side sources and straps come from outside the clock domain
  assign async_raw.reset_pin_n               = RESET_PIN_N;
  assign async_raw.wakeup                    = WAKEUP_REQUEST;
  assign async_raw.brownout                  = BROWNOUT_DETECT;
  assign async_raw.strap.boot_mode_config_pin = BOOT_MODE_CONFIG_PIN;
  assign async_raw.strap.tms                 = TMS_PIN;
  assign async_raw.strap.port0_bit0_strap    = PORT0_BIT0_STRAP;

  pin_sync3 #(
    .WIDTH       (6),
    .RESET_VALUE (reset_boot_pkg::SYNC_RESET_VALUE)
  ) u_sync (
    .clock    (CLOCK),
    .reset    (RESET),
    .async_in (async_raw),
    .stable   (async_s)
  );

  // Source vector; power-on is the asynchronous RESET itself
  always_comb begin
    src_vec = '0;
    src_vec[reset_boot_pkg::CAUSE_PIN]   = !async_s.reset_pin_n; // [RULE_01]
    src_vec[reset_boot_pkg::CAUSE_WDT]   = WATCHDOG_EXPIRE; // [RULE_01]
    src_vec[reset_boot_pkg::CAUSE_WAKE]  = async_s.wakeup; // [RULE_01]
    src_vec[reset_boot_pkg::CAUSE_BROWN] = async_s.brownout; // [RULE_01]
  end

  assign src_any      = |src_vec;
  assign release_now  = (state_reg == reset_boot_pkg::ST_STRETCH) && !src_any
                        && (cnt_reg == STRETCH_LAST);
  assign cold_release = release_now && (cause_reg[reset_boot_pkg::CAUSE_POR]
                        || cause_reg[reset_boot_pkg::CAUSE_PIN]);

  // Password check only redirects plain user mode to the loader
  always_comb begin
    strap_mode = decode_straps(async_s.strap);
    if (strap_mode == reset_boot_pkg::BOOT_USER && !PASSWORD_VALID && MEM_ZERO_AT_START) begin
      strap_mode = reset_boot_pkg::BOOT_LOADER; // [RULE_10]
    end
  end

  // Sequencer: hold while any source is active, stretch, then release
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    cause_next  = cause_reg;
    mode_next   = mode_reg;
    ram_next    = ram_reg;
    reg_on_next = reg_on_reg;
    start_next  = start_reg;
    case (state_reg)
      reset_boot_pkg::ST_HOLD: begin
        cause_next = cause_reg | src_vec;
        cnt_next   = '0;
        if (!src_any) begin
          state_next = reset_boot_pkg::ST_STRETCH;
        end
      end
      reset_boot_pkg::ST_STRETCH: begin
        cause_next = cause_reg | src_vec;
        if (src_any) begin
          state_next = reset_boot_pkg::ST_HOLD;
        end else if (cnt_reg == STRETCH_LAST) begin
          state_next = reset_boot_pkg::ST_RUN; // [RULE_13]
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
      reset_boot_pkg::ST_RUN: begin
        if (src_any) begin
          state_next = reset_boot_pkg::ST_HOLD;
          cause_next = src_vec;
        end
        if (POWER_DOWN_ENTRY) begin
          reg_on_next = 1'b0;
        end
      end
      default: begin
        state_next = reset_boot_pkg::ST_HOLD;
      end
    endcase
    if (release_now) begin
      // Pin, watchdog and wake-up resets keep RAM; power-on or brownout leaves it undefined
      ram_next = !(cause_reg[reset_boot_pkg::CAUSE_POR]
                   || cause_reg[reset_boot_pkg::CAUSE_BROWN]); // [RULE_04]
      if (cause_reg[reset_boot_pkg::CAUSE_WAKE]) begin
        reg_on_next = 1'b1; // [RULE_05]
      end
    end
    if (cold_release) begin
      mode_next  = strap_mode; // [RULE_02] [RULE_06] [RULE_13]
      start_next = reset_boot_pkg::BOOT_START_ADDRESS;
    end
  end

  // Outputs derived from the next state so each port is a flop
  always_comb begin
    sys_reset_next = (state_next != reset_boot_pkg::ST_RUN); // [RULE_13]
    jtag_next      = (mode_next == reset_boot_pkg::BOOT_USER_JTAG)
                     || (mode_next == reset_boot_pkg::BOOT_DEBUG); // [RULE_09]
    bypass_next    = (state_next == reset_boot_pkg::ST_RUN)
                     && (mode_next == reset_boot_pkg::BOOT_LOADER)
                     && CAN_LOADER_ACTIVE; // [RULE_11]
  end

  // Merged reset asserts at once with RESET, releases on the clock
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state_reg     <= reset_boot_pkg::ST_HOLD;
      cnt_reg       <= '0;
      cause_reg     <= reset_boot_pkg::CAUSE_RESET_VALUE;
      mode_reg      <= reset_boot_pkg::BOOT_USER;
      ram_reg       <= 1'b0;
      reg_on_reg    <= 1'b1;
      start_reg     <= reset_boot_pkg::START_ADDRESS_RESET;
      sys_reset_reg <= 1'b1;
      jtag_reg      <= 1'b0;
      bypass_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      cause_reg     <= cause_next;
      mode_reg      <= mode_next;
      ram_reg       <= ram_next;
      reg_on_reg    <= reg_on_next;
      start_reg     <= start_next;
      sys_reset_reg <= sys_reset_next;
      jtag_reg      <= jtag_next;
      bypass_reg    <= bypass_next;
    end
  end

  assign SYS_RESET        = sys_reset_reg;
  assign RESET_CAUSE      = cause_reg;
  assign RAM_RETAINED     = ram_reg;
  assign REGULATOR_ON     = reg_on_reg;
  assign BOOT_MODE        = mode_reg;
  assign START_ADDRESS    = start_reg;
  assign JTAG_PINS_ENABLE = jtag_reg;
  assign OSC_BYPASS       = bypass_reg;

  // Checks on the sequencer and the mode latch
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  sequence s_run_hit;
    (state_reg == reset_boot_pkg::ST_RUN) && src_any;
  endsequence

  sequence s_cold_loader;
    cold_release && !async_s.strap.tms && !async_s.strap.boot_mode_config_pin;
  endsequence

  AST_SOURCE_RESETS: assert property (s_run_hit |=> SYS_RESET ##0 state_reg == reset_boot_pkg::ST_HOLD) // [RULE_01]
    else $error("Active source did not reassert reset");
  AST_RELEASE_SYNC: assert property ($fell(SYS_RESET) |-> $past(release_now)) // [RULE_13]
    else $error("Reset released outside stretch end");
  AST_MODE_STABLE: assert property (!$past(cold_release) |-> $stable(BOOT_MODE)) // [RULE_02]
    else $error("Boot mode changed without cold release");
  AST_WARM_KEEPS_MODE: assert property (release_now && !cold_release |=> $stable(BOOT_MODE)) // [RULE_06]
    else $error("Warm reset changed boot mode");
  AST_LOADER_DECODE: assert property (s_cold_loader |=> BOOT_MODE == reset_boot_pkg::BOOT_LOADER) // [RULE_07]
    else $error("Loader strap not decoded");
  AST_DEBUG_DECODE: assert property (cold_release && async_s.strap.tms
    && !async_s.strap.port0_bit0_strap && !async_s.strap.boot_mode_config_pin
    |=> BOOT_MODE == reset_boot_pkg::BOOT_DEBUG) // [RULE_08]
    else $error("Debug strap not decoded");
  AST_JTAG_PINS: assert property (BOOT_MODE == reset_boot_pkg::BOOT_USER_JTAG |-> JTAG_PINS_ENABLE) // [RULE_09]
    else $error("JTAG pins off in JTAG user mode");
  AST_PASSWORD_LOADER: assert property (cold_release && !async_s.strap.tms
    && async_s.strap.boot_mode_config_pin && !PASSWORD_VALID && MEM_ZERO_AT_START
    |=> BOOT_MODE == reset_boot_pkg::BOOT_LOADER) // [RULE_10]
    else $error("Missing password did not force loader");
  AST_CAN_BYPASS: assert property (!SYS_RESET && BOOT_MODE == reset_boot_pkg::BOOT_LOADER
    && CAN_LOADER_ACTIVE && !src_any |=> OSC_BYPASS) // [RULE_11]
    else $error("CAN loader without oscillator bypass");
  AST_RAM_COLD: assert property (release_now && cause_reg[reset_boot_pkg::CAUSE_BROWN]
    |=> !RAM_RETAINED) // [RULE_04]
    else $error("RAM marked kept after brownout");
  AST_WAKE_REGULATOR: assert property (release_now && cause_reg[reset_boot_pkg::CAUSE_WAKE]
    |=> REGULATOR_ON) // [RULE_05]
    else $error("Wake reset left regulator off");

endmodule
`default_nettype wire

/* File: testbench/board_model.sv */
// Board-side model: external reset pin with timed hold and static strap levels
`timescale 1ns/1ns
`default_nettype none
module board_model #(
  parameter int HOLD_CYCLES = 8
) (
  input  wire logic                   clock,
  input  wire logic                   press,
  input  wire reset_boot_pkg::strap_t strap_set,
  output var  logic                   reset_pin_n,
  output var  reset_boot_pkg::strap_t strap
);
  int hold_count = 0;

  // Pin is held low a full span per press, scaled down from the power-up hold
  always @(posedge clock) begin
    if (press) begin
      hold_count <= HOLD_CYCLES;
    end else if (hold_count != 0) begin
      hold_count <= hold_count - 1;
    end
  end

  assign reset_pin_n = (hold_count == 0);

  // Straps sit on the default pin set; they are plain static levels
  assign strap = strap_set;
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for reset merging and boot mode latching
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int S = 4;
  typedef struct packed {
    logic [2:0] st;
    logic       pw;
    logic       mz;
    logic       can;
    logic [1:0] mode;
    logic       jt;
    logic       osc;
  } row_t;

  logic CLOCK = 0, RESET = 1, WATCHDOG_EXPIRE = 0, WAKEUP_REQUEST = 0;
  logic BROWNOUT_DETECT = 0, PASSWORD_VALID = 1, MEM_ZERO_AT_START = 0;
  logic CAN_LOADER_ACTIVE = 0, POWER_DOWN_ENTRY = 0, press = 0;
  logic SYS_RESET, RAM_RETAINED, REGULATOR_ON, JTAG_PINS_ENABLE, OSC_BYPASS, pin_n;
  logic [4:0] RESET_CAUSE;
  logic [1:0] BOOT_MODE;
  logic [15:0] START_ADDRESS;
  reset_boot_pkg::strap_t strap_set = '0, strap;
  row_t rows[12];
  int n_errors = 0, n_checks = 0, n;

  // Free-running system clock
  always #4 CLOCK = ~CLOCK;

  board_model i_board_model (.clock(CLOCK), .press(press), .strap_set(strap_set),
    .reset_pin_n(pin_n), .strap(strap));

  reset_boot_mode_select #(.STRETCH_CYCLES(S)) i_reset_boot_mode_select (
    .CLOCK(CLOCK), .RESET(RESET), .RESET_PIN_N(pin_n), .WATCHDOG_EXPIRE(WATCHDOG_EXPIRE),
    .WAKEUP_REQUEST(WAKEUP_REQUEST), .BROWNOUT_DETECT(BROWNOUT_DETECT),
    .BOOT_MODE_CONFIG_PIN(strap.boot_mode_config_pin), .TMS_PIN(strap.tms),
    .PORT0_BIT0_STRAP(strap.port0_bit0_strap), .PASSWORD_VALID(PASSWORD_VALID),
    .MEM_ZERO_AT_START(MEM_ZERO_AT_START), .CAN_LOADER_ACTIVE(CAN_LOADER_ACTIVE),
    .POWER_DOWN_ENTRY(POWER_DOWN_ENTRY), .SYS_RESET(SYS_RESET), .RESET_CAUSE(RESET_CAUSE),
    .RAM_RETAINED(RAM_RETAINED), .REGULATOR_ON(REGULATOR_ON), .BOOT_MODE(BOOT_MODE),
    .START_ADDRESS(START_ADDRESS), .JTAG_PINS_ENABLE(JTAG_PINS_ENABLE),
    .OSC_BYPASS(OSC_BYPASS));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Inputs move a fixed 1 ns after the edge, never on it
  task automatic tick();
    @(posedge CLOCK);
    #1;
  endtask

  // Bounded wait for the merged reset to rise and fall again
  task automatic wait_release();
    n = 0;
    while (SYS_RESET !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    while (SYS_RESET !== 1'b0 && n < 200) begin
      tick();
      n++;
    end
    check(SYS_RESET, 0, "reset never released");
    tick();
    tick();
  endtask

  // One source high for len cycles, then wait for release; 0 pin, 1 brownout, 2 wake
  task automatic pulse(input int src, input int len);
    press = (src == 0);
    BROWNOUT_DETECT = (src == 1);
    WAKEUP_REQUEST = (src == 2);
    repeat (len) tick();
    press = 0;
    BROWNOUT_DETECT = 0;
    WAKEUP_REQUEST = 0;
    wait_release();
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected run of a few hundred cycles
  initial begin
    #200000;
    n_errors++;
    test_done();
  end

  initial begin
    // Straps, side inputs, then expected mode, debug pins and bypass
    rows = '{'{3'h4, 1'h1, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0}, '{3'h5, 1'h1, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0},
             '{3'h1, 1'h1, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0}, '{3'h0, 1'h1, 1'h0, 1'h1, 2'h1, 1'h0, 1'h1},
             '{3'h2, 1'h1, 1'h0, 1'h0, 2'h2, 1'h1, 1'h0}, '{3'h6, 1'h1, 1'h0, 1'h0, 2'h3, 1'h1, 1'h0},
             '{3'h4, 1'h0, 1'h1, 1'h0, 2'h1, 1'h0, 1'h0}, '{3'h4, 1'h0, 1'h1, 1'h1, 2'h1, 1'h0, 1'h1},
             '{3'h6, 1'h0, 1'h1, 1'h0, 2'h3, 1'h1, 1'h0}, '{3'h4, 1'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0},
             '{3'h7, 1'h1, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0}, '{3'h3, 1'h1, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0}};
    repeat (4) tick();
    RESET = 0;
    wait_release();
    check(BOOT_MODE, 2'h1, "mode after power-on");
    check(RAM_RETAINED, 0, "ram after power-on");
    for (int i = 0; i < 12; i++) begin
      strap_set = rows[i].st;
      PASSWORD_VALID = rows[i].pw;
      MEM_ZERO_AT_START = rows[i].mz;
      CAN_LOADER_ACTIVE = rows[i].can;
      pulse(0, 1);
      check(BOOT_MODE, rows[i].mode, "boot mode");
      check(START_ADDRESS, 16'h0000, "start address");
      check(JTAG_PINS_ENABLE, rows[i].jt, "debug pins");
      check(OSC_BYPASS, rows[i].osc, "oscillator bypass");
      check(RESET_CAUSE, 5'h02, "cause pin");
      check(RAM_RETAINED, 1, "ram after pin reset");
    end
    // Straps now differ from the latched user mode; warm resets must keep it
    strap_set = 3'h2;
    CAN_LOADER_ACTIVE = 0;
    repeat (6) tick();
    check(BOOT_MODE, 2'h0, "mode moved while running");
    WATCHDOG_EXPIRE = 1;
    tick();
    WATCHDOG_EXPIRE = 0;
    check(RESET_CAUSE, 5'h04, "cause watchdog");
    n = 0;
    while (SYS_RESET === 1'b1 && n < 50) begin
      n++;
      tick();
    end
    check(n, S + 1, "watchdog hold length");
    check(BOOT_MODE, 2'h0, "mode after watchdog");
    check(RAM_RETAINED, 1, "ram after watchdog");
    // A source during the stretch restarts the hold from the start
    WATCHDOG_EXPIRE = 1;
    tick();
    WATCHDOG_EXPIRE = 0;
    repeat (2) tick();
    check(SYS_RESET, 1, "still held in stretch");
    WATCHDOG_EXPIRE = 1;
    tick();
    WATCHDOG_EXPIRE = 0;
    n = 0;
    while (SYS_RESET === 1'b1 && n < 50) begin
      n++;
      tick();
    end
    check(n, S + 1, "hold restarted by source in stretch");
    pulse(1, 6);
    check(RESET_CAUSE, 5'h10, "cause brownout");
    check(RAM_RETAINED, 0, "ram after brownout");
    check(BOOT_MODE, 2'h0, "mode after brownout");
    POWER_DOWN_ENTRY = 1;
    tick();
    POWER_DOWN_ENTRY = 0;
    tick();
    check(REGULATOR_ON, 0, "regulator in power-down");
    pulse(2, 6);
    check(RESET_CAUSE, 5'h08, "cause wake-up");
    check(REGULATOR_ON, 1, "regulator after wake-up");
    check(RAM_RETAINED, 1, "ram after wake-up");
    check(BOOT_MODE, 2'h0, "mode after wake-up");
    // Power-on reset in mid-run: outputs fall back at once, straps taken on release
    RESET = 1;
    #1;
    check(SYS_RESET, 1, "reset asserted asynchronously");
    check(RESET_CAUSE, 5'h01, "cause power-on");
    check(REGULATOR_ON, 1, "regulator in power-on");
    tick();
    RESET = 0;
    wait_release();
    check(BOOT_MODE, 2'h2, "debug mode after power-on");
    check(JTAG_PINS_ENABLE, 1, "debug pins after power-on");
    check(RAM_RETAINED, 0, "ram after second power-on");
    test_done();
  end
endmodule
`default_nettype wire
